// *** logic/wdt_prescaler.v ***
// Purpose: System clock prescaler, held clear while run is low, giving one-cycle tick enables.
// Assumes: One clock domain, active-low asynchronous reset.
// Notes: Divide ratios 2,64,128,256,512,1024,4096,8192 picked by a 3-bit select.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_regs.vh"
module wdt_prescaler (
  // Clock and reset.
  input wire sys_clk,
  input wire rst_n,
  // Control.
  input wire run,
  input wire [2:0] divider_select,
  // Tick enable.
  output reg tick
);
  reg [`WDT_PRESCALE_W-1:0] count_reg;
  reg [`WDT_PRESCALE_W-1:0] mask;

  // Map the divider select to a low-bit mask; a tick fires when the masked bits wrap.
  always @* begin
    case (divider_select)
      3'd0: mask = 13'h0001;
      3'd1: mask = 13'h003F;
      3'd2: mask = 13'h007F;
      3'd3: mask = 13'h00FF;
      3'd4: mask = 13'h01FF;
      3'd5: mask = 13'h03FF;
      3'd6: mask = 13'h0FFF;
      default: mask = 13'h1FFF;
    endcase
  end

  // Count while running and pulse tick once per selected period.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 13'h0000;
      tick <= 1'b0;
    end else if (!run) begin
      count_reg <= 13'h0000;
      tick <= 1'b0;
    end else begin
      count_reg <= count_reg + 13'h0001;
      tick <= ((count_reg & mask) == mask);
    end
  end
endmodule
`default_nettype wire

// *** logic/wdt_regs.vh ***
// Purpose: Register offsets, field positions, reset values and timing counts of the watchdog.
// Assumes: Byte addresses on the internal peripheral bus, 20 MHz system clock.
// Notes: Definitions only.
`ifndef WDT_REGS_VH
`define WDT_REGS_VH
`define WDT_ADDR_W 28
`define WDT_CTRL_ADDR 28'h5FF_FFB8
`define WDT_COUNT_ADDR 28'h5FF_FFB9
`define WDT_RST_WADDR 28'h5FF_FFBA
`define WDT_RST_RADDR 28'h5FF_FFBB
`define WDT_KEY_COUNT 8'h5A
`define WDT_KEY_CTRL 8'hA5
`define WDT_KEY_RST_SET 8'h5A
`define WDT_KEY_RST_CLR 8'hA5
`define WDT_RST_CLR_DATA 8'h00
`define WDT_BIT_OVF 7
`define WDT_BIT_MODE 6
`define WDT_BIT_RUN 5
`define WDT_BIT_WATCHDOG_OVERFLOW_FLAG 7
`define WDT_BIT_RESET_ON_OVERFLOW_ENABLE 6
`define WDT_BIT_RESET_KIND_SELECT 5
`define WDT_CTRL_RESERVED 8'h18
`define WDT_RST_RESERVED 8'h1F
`define WDT_COUNT_RESET 8'h00
`define WDT_COUNT_MAX 8'hFF
`define WDT_OVF_OUT_CYCLES 10'd128
`define WDT_CHIP_RST_CYCLES 10'd512
`define WDT_PRESCALE_W 13
`endif

// *** logic/wdt_unit.v ***
// Purpose: Eight-bit watchdog and interval timer with keyed word writes and byte reads.
// Assumes: Single-cycle internal bus strobes on sys_clk; bus write strobe marks the T3 state.
// Notes: Also times oscillator settling on wake from standby.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_regs.vh"
module wdt_unit #(
  parameter OVF_OUT_CYCLES = 128,
  parameter CHIP_RST_CYCLES = 512
) (
  // Clock and reset.
  input wire sys_clk,
  input wire rst_n,
  // Board reset pin, asynchronous to the clock domain.
  input wire external_reset_n,
  // Internal peripheral bus.
  input wire [`WDT_ADDR_W-1:0] bus_addr,
  input wire bus_wr,
  input wire bus_rd,
  input wire bus_word,
  input wire [15:0] bus_wdata,
  output reg [7:0] bus_rdata,
  // Power-down controller handshake.
  input wire standby_request,
  input wire nmi_request,
  output reg standby_grant,
  output reg in_standby,
  // Events.
  output reg interval_interrupt,
  output reg overflow_out_n,
  output reg power_on_reset_req,
  output reg manual_reset_req
);
  localparam ST_RUN = 3'b001;
  localparam ST_SLEEP = 3'b010;
  localparam ST_WAKE = 3'b100;

  reg ext_sync1_reg;
  reg ext_sync2_reg;
  reg [7:0] watchdog_count_reg;
  reg interval_overflow_flag_reg;
  reg watchdog_or_interval_select_reg;
  reg timer_run_enable_reg;
  reg [2:0] tick_divider_select_reg;
  reg watchdog_overflow_flag_reg;
  reg reset_on_overflow_enable_reg;
  reg reset_kind_select_reg;
  reg ovf_read_reg;
  reg watchdog_overflow_flag_read_reg;
  reg [9:0] ovf_out_cnt_reg;
  reg [9:0] chip_rst_cnt_reg;
  reg [2:0] state_reg;
  wire tick;
  wire count_run;
  wire overflow;
  wire word_wr;
  wire ctrl_write;
  wire count_write;
  wire rst_set_write;
  wire rst_clr_write;
  wire wd_ovf;
  wire iv_ovf;
  wire wake_ovf;
  wire ext_reset;
  wire [7:0] ctrl_view;
  wire [7:0] rst_view;

  // Compose the readable control and reset registers.
  assign ctrl_view = {interval_overflow_flag_reg, watchdog_or_interval_select_reg,
                      timer_run_enable_reg, 2'b11, tick_divider_select_reg};
  assign rst_view = {watchdog_overflow_flag_reg, reset_on_overflow_enable_reg,
                     reset_kind_select_reg, 5'b11111};

  // Keyed word writes; byte writes never match.
  assign word_wr = bus_wr & bus_word;
  assign count_write = word_wr & (bus_addr == `WDT_CTRL_ADDR) &
                       (bus_wdata[15:8] == `WDT_KEY_COUNT);
  assign ctrl_write = word_wr & (bus_addr == `WDT_CTRL_ADDR) &
                      (bus_wdata[15:8] == `WDT_KEY_CTRL);
  assign rst_set_write = word_wr & (bus_addr == `WDT_RST_WADDR) &
                         (bus_wdata[15:8] == `WDT_KEY_RST_SET);
  assign rst_clr_write = word_wr & (bus_addr == `WDT_RST_WADDR) &
                         (bus_wdata[15:8] == `WDT_KEY_RST_CLR) &
                         (bus_wdata[7:0] == `WDT_RST_CLR_DATA);

  // Counter runs when enabled, or while waking from standby.
  assign count_run = timer_run_enable_reg | (state_reg == ST_WAKE);
  assign overflow = tick & ~count_write & (watchdog_count_reg == `WDT_COUNT_MAX);
  assign wd_ovf = overflow & timer_run_enable_reg & watchdog_or_interval_select_reg;
  assign iv_ovf = overflow & timer_run_enable_reg & ~watchdog_or_interval_select_reg;
  assign wake_ovf = overflow & (state_reg == ST_WAKE);
  assign ext_reset = ~ext_sync2_reg;

  // Prescaler for the counter tick.
  wdt_prescaler u_prescaler (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .run(count_run),
    .divider_select(tick_divider_select_reg),
    .tick(tick)
  );

  // Two-stage synchroniser for the board reset pin.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_sync1_reg <= 1'b1;
      ext_sync2_reg <= 1'b1;
    end else begin
      ext_sync1_reg <= external_reset_n;
      ext_sync2_reg <= ext_sync1_reg;
    end
  end

  // Counter and timer control register.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_count_reg <= `WDT_COUNT_RESET;
      interval_overflow_flag_reg <= 1'b0;
      watchdog_or_interval_select_reg <= 1'b0;
      timer_run_enable_reg <= 1'b0;
      tick_divider_select_reg <= 3'b000;
      ovf_read_reg <= 1'b0;
    end else if (ext_reset || (wd_ovf && !reset_on_overflow_enable_reg)) begin
      watchdog_count_reg <= `WDT_COUNT_RESET;
      interval_overflow_flag_reg <= 1'b0;
      watchdog_or_interval_select_reg <= 1'b0;
      timer_run_enable_reg <= 1'b0;
      tick_divider_select_reg <= 3'b000;
      ovf_read_reg <= 1'b0;
    end else if (state_reg == ST_SLEEP) begin
      // Standby clears mode, enable and flag, keeps the divider.
      watchdog_count_reg <= `WDT_COUNT_RESET;
      interval_overflow_flag_reg <= 1'b0;
      watchdog_or_interval_select_reg <= 1'b0;
      timer_run_enable_reg <= 1'b0;
      ovf_read_reg <= 1'b0;
    end else begin
      if (!count_run) begin
        watchdog_count_reg <= `WDT_COUNT_RESET;
      end else if (count_write) begin
        watchdog_count_reg <= bus_wdata[7:0];
      end else if (tick) begin
        watchdog_count_reg <= watchdog_count_reg + 8'h01;
      end
      if (bus_rd && bus_addr == `WDT_CTRL_ADDR && interval_overflow_flag_reg) begin
        ovf_read_reg <= 1'b1;
      end
      if (iv_ovf) begin
        interval_overflow_flag_reg <= 1'b1;
      end else if (ctrl_write && ovf_read_reg && !bus_wdata[`WDT_BIT_OVF]) begin
        interval_overflow_flag_reg <= 1'b0;
        ovf_read_reg <= 1'b0;
      end
      if (ctrl_write) begin
        watchdog_or_interval_select_reg <= bus_wdata[`WDT_BIT_MODE];
        timer_run_enable_reg <= bus_wdata[`WDT_BIT_RUN];
        tick_divider_select_reg <= bus_wdata[2:0];
      end
    end
  end

  // Reset control register; the board reset clears it and wins over an overflow.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_overflow_flag_reg <= 1'b0;
      reset_on_overflow_enable_reg <= 1'b0;
      reset_kind_select_reg <= 1'b0;
      watchdog_overflow_flag_read_reg <= 1'b0;
    end else if (ext_reset || state_reg == ST_SLEEP) begin
      watchdog_overflow_flag_reg <= 1'b0;
      reset_on_overflow_enable_reg <= 1'b0;
      reset_kind_select_reg <= 1'b0;
      watchdog_overflow_flag_read_reg <= 1'b0;
    end else begin
      if (bus_rd && bus_addr == `WDT_RST_RADDR && watchdog_overflow_flag_reg) begin
        watchdog_overflow_flag_read_reg <= 1'b1;
      end
      if (wd_ovf) begin
        watchdog_overflow_flag_reg <= 1'b1;
      end else if (rst_clr_write) begin
        watchdog_overflow_flag_reg <= 1'b0;
        watchdog_overflow_flag_read_reg <= 1'b0;
      end
      if (rst_set_write) begin
        reset_on_overflow_enable_reg <= bus_wdata[`WDT_BIT_RESET_ON_OVERFLOW_ENABLE];
        reset_kind_select_reg <= bus_wdata[`WDT_BIT_RESET_KIND_SELECT];
      end
    end
  end

  // Overflow pin pulse and internal chip reset timers.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_out_cnt_reg <= 10'd0;
      chip_rst_cnt_reg <= 10'd0;
      overflow_out_n <= 1'b1;
      power_on_reset_req <= 1'b0;
      manual_reset_req <= 1'b0;
    end else begin
      if (wd_ovf) begin
        ovf_out_cnt_reg <= OVF_OUT_CYCLES[9:0] - 10'd1;
        overflow_out_n <= 1'b0;
      end else if (ovf_out_cnt_reg != 10'd0) begin
        ovf_out_cnt_reg <= ovf_out_cnt_reg - 10'd1;
      end else begin
        overflow_out_n <= 1'b1;
      end
      if (ext_reset) begin
        chip_rst_cnt_reg <= 10'd0;
        power_on_reset_req <= 1'b0;
        manual_reset_req <= 1'b0;
      end else if (wd_ovf && reset_on_overflow_enable_reg) begin
        chip_rst_cnt_reg <= CHIP_RST_CYCLES[9:0] - 10'd1;
        power_on_reset_req <= ~reset_kind_select_reg;
        manual_reset_req <= reset_kind_select_reg;
      end else if (chip_rst_cnt_reg != 10'd0) begin
        chip_rst_cnt_reg <= chip_rst_cnt_reg - 10'd1;
      end else begin
        power_on_reset_req <= 1'b0;
        manual_reset_req <= 1'b0;
      end
    end
  end

  // Read data, interrupt and standby handshake.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= 8'h00;
      interval_interrupt <= 1'b0;
      state_reg <= ST_RUN;
      standby_grant <= 1'b0;
      in_standby <= 1'b0;
    end else begin
      bus_rdata <= 8'h00;
      if (bus_rd) begin
        case (bus_addr)
          `WDT_CTRL_ADDR: bus_rdata <= ctrl_view;
          `WDT_COUNT_ADDR: bus_rdata <= watchdog_count_reg;
          `WDT_RST_RADDR: bus_rdata <= rst_view;
          default: bus_rdata <= 8'h00;
        endcase
      end
      interval_interrupt <= iv_ovf;
      standby_grant <= 1'b0;
      case (state_reg)
        ST_RUN: begin
          if (standby_request && !timer_run_enable_reg && !ext_reset) begin
            state_reg <= ST_SLEEP;
            standby_grant <= 1'b1;
            in_standby <= 1'b1;
          end
        end
        ST_SLEEP: begin
          if (nmi_request) begin
            state_reg <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (wake_ovf) begin
            state_reg <= ST_RUN;
            in_standby <= 1'b0;
          end
        end
        default: state_reg <= ST_RUN;
      endcase
      if (ext_reset) begin
        state_reg <= ST_RUN;
        in_standby <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/test_watchdog_interval_timer.sv ***
// Purpose: Self-checking bench for the watchdog unit.
// Assumes: Pulse lengths shortened to 4 and 8 cycles.
// Notes: Bus cycles come from the processor model.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_regs.vh"
module test_watchdog_interval_timer;
  logic sys_clk, rst_n, external_reset_n, standby_request, nmi_request, saw_low;
  logic [7:0] q;
  wire [27:0] bus_addr;
  wire bus_wr, bus_rd, bus_word;
  wire [15:0] bus_wdata;
  wire [7:0] bus_rdata;
  wire standby_grant, in_standby, interval_interrupt, overflow_out_n, por, man;
  int n_fail, cmp_count, i, k;
  wdt_unit #(.OVF_OUT_CYCLES(4), .CHIP_RST_CYCLES(8)) wdt_unit_inst (.sys_clk(sys_clk),
    .rst_n(rst_n), .external_reset_n(external_reset_n), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_word(bus_word), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .standby_request(standby_request), .nmi_request(nmi_request), .standby_grant(standby_grant),
    .in_standby(in_standby), .interval_interrupt(interval_interrupt),
    .overflow_out_n(overflow_out_n), .power_on_reset_req(por), .manual_reset_req(man));
  wdt_cpu wdt_cpu_inst (.sys_clk(sys_clk), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_word(bus_word), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));
  // 20 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Remember any overflow pulse seen.
  always @(negedge sys_clk) if (overflow_out_n === 1'b0) saw_low = 1'b1;
  task chk(input logic [7:0] got, input logic [7:0] exp);
    begin
      cmp_count++;
      if (got !== exp) begin
        n_fail++;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task rchk(input logic [27:0] a, input logic [7:0] exp);
    begin
      wdt_cpu_inst.rd(a, q);
      chk(q, exp);
    end
  endtask
  // Arm the watchdog with the counter one tick from overflow, wait for the pulse.
  task fire(input logic [15:0] rst_ctl);
    begin
      wdt_cpu_inst.wr(`WDT_RST_WADDR, rst_ctl, 1'b1);
      wdt_cpu_inst.wr(`WDT_CTRL_ADDR, 16'hA560, 1'b1);
      wdt_cpu_inst.wr(`WDT_CTRL_ADDR, 16'h5AFF, 1'b1);
      for (i = 0; i < 20 && overflow_out_n !== 1'b0; i++) @(negedge sys_clk);
    end
  endtask
  task give_verdict;
    begin
      $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
        $display("*** PASS ***");
      end else begin
        $display("*** FAIL ***");
      end
      $finish;
    end
  endtask
  // Cut a hang short.
  initial begin
    #1000000;
    n_fail++;
    give_verdict();
  end
  // Main sequence.
  initial begin
    rst_n = 1'b0;
    external_reset_n = 1'b1;
    standby_request = 1'b0;
    nmi_request = 1'b0;
    saw_low = 1'b0;
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    rchk(`WDT_CTRL_ADDR, 8'h18);
    rchk(`WDT_COUNT_ADDR, 8'h00);
    rchk(`WDT_RST_RADDR, 8'h1F);
    rchk(`WDT_RST_WADDR, 8'h00);
    wdt_cpu_inst.wr(`WDT_CTRL_ADDR, 16'hA560, 1'b0);
    wdt_cpu_inst.wr(`WDT_CTRL_ADDR, 16'h3C60, 1'b1);
    wdt_cpu_inst.wr(`WDT_RST_WADDR, 16'h5A60, 1'b0);
    wdt_cpu_inst.wr(`WDT_CTRL_ADDR, 16'h5A10, 1'b1);
    rchk(`WDT_CTRL_ADDR, 8'h18);
    rchk(`WDT_RST_RADDR, 8'h1F);
    rchk(`WDT_COUNT_ADDR, 8'h00);
    wdt_cpu_inst.wr(`WDT_RST_WADDR, 16'h5A60, 1'b1);
    rchk(`WDT_RST_RADDR, 8'h7F);
    wdt_cpu_inst.wr(`WDT_CTRL_ADDR, 16'hA520, 1'b1);
    wdt_cpu_inst.wr(`WDT_CTRL_ADDR, 16'h5AFF, 1'b1);
    for (i = 0; i < 20 && interval_interrupt !== 1'b1; i++) @(negedge sys_clk);
    chk({7'h00, interval_interrupt}, 8'h01);
    wdt_cpu_inst.wr(`WDT_CTRL_ADDR, 16'hA520, 1'b1);
    rchk(`WDT_CTRL_ADDR, 8'hB8);
    wdt_cpu_inst.wr(`WDT_CTRL_ADDR, 16'hA520, 1'b1);
    rchk(`WDT_CTRL_ADDR, 8'h38);
    wdt_cpu_inst.wr(`WDT_CTRL_ADDR, 16'hA518, 1'b1);
    wdt_cpu_inst.wr(`WDT_CTRL_ADDR, 16'hA521, 1'b1);
    wdt_cpu_inst.wr(`WDT_CTRL_ADDR, 16'h5AFF, 1'b1);
    for (i = 0; i < 200 && interval_interrupt !== 1'b1; i++) @(negedge sys_clk);
    chk({7'h00, i >= 60 && i <= 64}, 8'h01);
    wdt_cpu_inst.wr(`WDT_CTRL_ADDR, 16'hA518, 1'b1);
    for (k = 0; k < 2; k++) begin
      fire(k ? 16'h5A60 : 16'h5A40);
      chk({5'h00, overflow_out_n, por, man}, k ? 8'h01 : 8'h02);
      rchk(`WDT_RST_RADDR, k ? 8'hFF : 8'hDF);
      wdt_cpu_inst.wr(`WDT_RST_WADDR, 16'hA500, 1'b1);
      rchk(`WDT_RST_RADDR, k ? 8'h7F : 8'h5F);
      wdt_cpu_inst.wr(`WDT_CTRL_ADDR, 16'hA518, 1'b1);
      repeat (10) @(negedge sys_clk);
    end
    saw_low = 1'b0;
    wdt_cpu_inst.wr(`WDT_CTRL_ADDR, 16'hA560, 1'b1);
    repeat (4) begin
      repeat (200) @(negedge sys_clk);
      wdt_cpu_inst.wr(`WDT_CTRL_ADDR, 16'h5A00, 1'b1);
    end
    chk({7'h00, saw_low}, 8'h00);
    wdt_cpu_inst.wr(`WDT_CTRL_ADDR, 16'hA518, 1'b1);
    fire(16'h5A00);
    repeat (10) @(negedge sys_clk);
    rchk(`WDT_CTRL_ADDR, 8'h18);
    rchk(`WDT_COUNT_ADDR, 8'h00);
    fire(16'h5A40);
    external_reset_n = 1'b0;
    repeat (10) @(negedge sys_clk);
    external_reset_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    rchk(`WDT_RST_RADDR, 8'h1F);
    chk({6'h00, por, man}, 8'h00);
    wdt_cpu_inst.wr(`WDT_CTRL_ADDR, 16'hA520, 1'b1);
    standby_request = 1'b1;
    repeat (10) @(negedge sys_clk);
    chk({6'h00, standby_grant, in_standby}, 8'h00);
    standby_request = 1'b0;
    wdt_cpu_inst.wr(`WDT_CTRL_ADDR, 16'hA500, 1'b1);
    standby_request = 1'b1;
    for (i = 0; i < 10 && in_standby !== 1'b1; i++) @(negedge sys_clk);
    chk({7'h00, in_standby}, 8'h01);
    standby_request = 1'b0;
    nmi_request = 1'b1;
    @(negedge sys_clk);
    nmi_request = 1'b0;
    for (i = 0; i < 2000 && in_standby !== 1'b0; i++) @(negedge sys_clk);
    chk({7'h00, i >= 500 && i <= 530}, 8'h01);
    give_verdict();
  end
endmodule
`default_nettype wire

// *** verification/wdt_cpu.sv ***
// Purpose: Processor model issuing single-cycle peripheral bus cycles.
// Assumes: Requests change at the falling edge, taken at the next rising edge.
// Notes: Released lines carry inverted values so stale data is never trusted.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_regs.vh"
module wdt_cpu (
  // Clock.
  input wire logic sys_clk,
  // Bus towards the watchdog.
  output var logic [`WDT_ADDR_W-1:0] bus_addr,
  output var logic bus_wr,
  output var logic bus_rd,
  output var logic bus_word,
  output var logic [15:0] bus_wdata,
  input wire logic [7:0] bus_rdata
);
  // Bus idle at time zero.
  initial begin
    bus_addr = 28'h000_0000;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_word = 1'b0;
    bus_wdata = 16'h0000;
  end
  // Keyed write: key in the upper byte, data in the lower byte.
  task wr(input logic [27:0] a, input logic [15:0] d, input logic w);
    begin
      @(negedge sys_clk);
      bus_addr = a;
      bus_wdata = d;
      bus_word = w;
      bus_wr = 1'b1;
      @(negedge sys_clk);
      bus_wr = 1'b0;
      bus_wdata = ~d;
      bus_addr = ~a;
    end
  endtask
  // Byte read; data is taken the cycle after the strobe.
  task rd(input logic [27:0] a, output logic [7:0] q);
    begin
      @(negedge sys_clk);
      bus_addr = a;
      bus_word = 1'b0;
      bus_rd = 1'b1;
      @(negedge sys_clk);
      q = bus_rdata;
      bus_rd = 1'b0;
      bus_addr = ~a;
    end
  endtask
endmodule
`default_nettype wire

// *** verification/wdt_monitor.sv ***
// Purpose: Port checks on the watchdog unit.
// Assumes: One clock, pulse lengths passed in by parameter.
// Notes: Bound to the unit below the module.
`timescale 1ns/10ps
`default_nettype none
module wdt_monitor #(
  parameter OVF_OUT_CYCLES = 128,
  parameter CHIP_RST_CYCLES = 512
) (
  // Clock and resets.
  input wire sys_clk,
  input wire rst_n,
  input wire external_reset_n,
  // Bus read side.
  input wire bus_rd,
  input wire [7:0] bus_rdata,
  // Standby and events.
  input wire standby_request,
  input wire standby_grant,
  input wire in_standby,
  input wire interval_interrupt,
  input wire overflow_out_n,
  input wire power_on_reset_req,
  input wire manual_reset_req
);
  reg [9:0] lo_cnt;
  reg [9:0] rq_cnt;
  wire any_rq = power_on_reset_req | manual_reset_req;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Count how long the overflow pulse and the reset request have lasted.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_cnt <= 10'h000;
      rq_cnt <= 10'h000;
    end else begin
      lo_cnt <= overflow_out_n ? 10'h000 : lo_cnt + 10'h001;
      rq_cnt <= any_rq ? rq_cnt + 10'h001 : 10'h000;
    end
  end
  sequence s_ovf_start;
    $fell(overflow_out_n);
  endsequence
  property p_ovf_len;
    disable iff (!rst_n || !external_reset_n) $rose(overflow_out_n) |-> lo_cnt == OVF_OUT_CYCLES;
  endproperty
  property p_ovf_cap;
    !overflow_out_n |-> lo_cnt < OVF_OUT_CYCLES;
  endproperty
  property p_rst_len;
    disable iff (!rst_n || !external_reset_n) $fell(any_rq) |-> rq_cnt == CHIP_RST_CYCLES;
  endproperty
  property p_rst_sync;
    $rose(any_rq) |-> s_ovf_start;
  endproperty
  property p_kind;
    !(power_on_reset_req && manual_reset_req);
  endproperty
  property p_iti_pulse;
    interval_interrupt |=> !interval_interrupt;
  endproperty
  property p_mode_excl;
    interval_interrupt |-> overflow_out_n && !any_rq;
  endproperty
  property p_rdata_idle;
    !$past(bus_rd) |-> bus_rdata == 8'h00;
  endproperty
  property p_grant;
    standby_grant |-> in_standby && $past(standby_request);
  endproperty
  a_ovf_len: assert property (p_ovf_len) else $error("overflow pulse length wrong");
  a_ovf_cap: assert property (p_ovf_cap) else $error("overflow pulse too long");
  a_rst_len: assert property (p_rst_len) else $error("reset request length wrong");
  a_rst_sync: assert property (p_rst_sync) else $error("reset not with overflow");
  a_kind: assert property (p_kind) else $error("both reset kinds raised");
  a_iti_pulse: assert property (p_iti_pulse) else $error("interrupt not one cycle");
  a_mode_excl: assert property (p_mode_excl) else $error("interrupt during watchdog pulse");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  a_grant: assert property (p_grant) else $error("standby grant wrong");
endmodule
bind wdt_unit wdt_monitor #(
  .OVF_OUT_CYCLES(OVF_OUT_CYCLES),
  .CHIP_RST_CYCLES(CHIP_RST_CYCLES)
) wdt_monitor_inst (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .external_reset_n(external_reset_n),
  .bus_rd(bus_rd),
  .bus_rdata(bus_rdata),
  .standby_request(standby_request),
  .standby_grant(standby_grant),
  .in_standby(in_standby),
  .interval_interrupt(interval_interrupt),
  .overflow_out_n(overflow_out_n),
  .power_on_reset_req(power_on_reset_req),
  .manual_reset_req(manual_reset_req)
);
`default_nettype wire
